// File: snm_sync.sv
/*
 * Shared constants for the two-wire memory controller, and the
 * two-flop synchroniser used on every pin that the controller reads.
 * Assumes a single 100 MHz system clock and an async active-low reset.
 */
`timescale 1ns/100ps

package snm_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	// Quarter of a 100 kHz bit period; least time, so round up
	localparam int unsigned T_QTR_NS      = 2500;
	localparam int unsigned QTR_CYC       = (T_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned ADDR_W        = 13;
	localparam int unsigned LEN_W         = 8;
	localparam logic [3:0]  ACK_BIT       = 4'h8;
	localparam logic [3:0]  LAST_BIT      = 4'h7;
	localparam logic [2:0]  HI_ADDR_PAD   = 3'h0;
	localparam logic        RW_READ       = 1'b1;
	localparam logic        RW_WRITE      = 1'b0;
	localparam logic [1:0]  Q_DRIVE       = 2'h0;
	localparam logic [1:0]  Q_RISE        = 2'h1;
	localparam logic [1:0]  Q_HIGH        = 2'h2;
	localparam logic [1:0]  Q_FALL        = 2'h3;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_START = 2'b01,
		ST_BITS  = 2'b10,
		ST_STOP  = 2'b11
	} snm_state_t;

	typedef enum logic [2:0] {
		SQ_DEVW  = 3'b000,
		SQ_AHI   = 3'b001,
		SQ_ALO   = 3'b010,
		SQ_DEVR  = 3'b011,
		SQ_WDATA = 3'b100,
		SQ_RDATA = 3'b101
	} snm_seq_t;
endpackage

module snm_sync #(
	parameter logic RESET_VAL = 1'b1
) (
	input  wire logic clk_sys,
	input  wire logic rstn,
	input  wire logic pin_in,
	output logic      pin_sync
);
	logic meta_reg;
	logic sync_reg;

	// First stage feeds only the second stage
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			meta_reg <= RESET_VAL;
			sync_reg <= RESET_VAL;
		end else begin
			meta_reg <= pin_in;
			sync_reg <= meta_reg;
		end
	end

	assign pin_sync = sync_reg;
endmodule

// File: snm_ctrl.sv
/*
 * Bus master for a byte-wide two-wire nonvolatile memory: start, slave
 * address, two address bytes, sequential writes and reads, stop.
 * Assumes open-drain pins resolved outside (oe high pulls the line low)
 * and a user that keeps a command stable while cmd_valid is high.
 */
`timescale 1ns/100ps

// Contract
// R1: Stop is SDA rising while SCL high.
// R2: Start is SDA falling while SCL high.
// R3: SDA steady while SCL high otherwise.
// R4: Ninth bit is acknowledge; transmitter releases SDA.
// R5: Device aborts on no-acknowledge from receiver.
// R6: Device keeps sending while master acknowledges.
// R7: Slave address holds type and select bits.
// R8: Address bit zero: one read, zero write.
// R9: Two address bytes, high first, top three ignored.
// R10: Device latch holds current address.
// R11: Device increments latch, wraps to zero.
// R12: Device allows unlimited sequential bytes.
// R13: Every byte goes most significant bit first.
// R14: Device stores byte after its eighth bit.
// R15: Device adds no busy time after writes.
// R16: Protected device refuses data bytes.
// R17: Protection off when input low.
// R18: Read data starts after address acknowledge.
// R19: Master ends read with no-acknowledge, stop.
// R20: Master stops only while owning SDA.
// R21: Master issues start before any operation.
// R22: Device samples rising, changes falling edge.
// R23: Select inputs read zero when open.
// R24: Device ignores mismatched slave address.
// R25: Device releases SDA in acknowledged slot.
module snm_ctrl #(
	parameter logic [3:0]  DEV_TYPE = 4'h5,              // Arbitrary value, set per system
	parameter int unsigned QTR_CYC  = snm_pkg::QTR_CYC   // Quarter-bit length in system clocks
) (
	input  wire logic                          clk_sys,
	input  wire logic                          rstn,
	input  wire logic                          cmd_valid,
	input  wire logic                          cmd_read,
	input  wire logic                          cmd_set_addr,
	input  wire logic [2:0]                    cmd_sel,
	input  wire logic [snm_pkg::ADDR_W-1:0]    cmd_addr,
	input  wire logic [snm_pkg::LEN_W-1:0]     cmd_len,
	output logic                               cmd_ready,
	input  wire logic [7:0]                    wr_data,
	input  wire logic                          wr_valid,
	output logic                               wr_take,
	output logic [7:0]                         rd_data,
	output logic                               rd_valid,
	output logic                               done,
	output logic                               nack_err,
	input  wire logic                          wp_req,
	output logic                               wp_o,
	input  wire logic                          scl_i,
	output logic                               scl_o,
	output logic                               scl_oe,
	input  wire logic                          sda_i,
	output logic                               sda_o,
	output logic                               sda_oe
);
	snm_pkg::snm_state_t          state_reg, state_next;
	snm_pkg::snm_seq_t            seq_reg, seq_next;
	logic [1:0]                   q_reg, q_next;
	logic [3:0]                   bit_reg, bit_next;
	logic [7:0]                   sh_reg, sh_next;
	logic [snm_pkg::LEN_W-1:0]    rem_reg, rem_next;
	logic                         read_reg, read_next;
	logic [2:0]                   sel_reg, sel_next;
	logic [snm_pkg::ADDR_W-1:0]   addr_reg, addr_next;
	logic                         nak_reg, nak_next;
	logic                         scl_oe_reg, scl_oe_next;
	logic                         sda_oe_reg, sda_oe_next;
	logic [7:0]                   rd_data_reg, rd_data_next;
	logic                         rd_valid_reg, rd_valid_next;
	logic                         wr_take_reg, wr_take_next;
	logic                         done_reg, done_next;
	logic                         nack_reg, nack_next;
	logic                         ready_reg;
	logic                         wp_reg;
	logic [15:0]                  qcnt_reg, qcnt_next;
	logic                         tick;
	logic                         scl_s;
	logic                         sda_s;
	logic                         xmit;
	logic                         hold;
	logic [7:0]                   load_byte;
	logic                         load;

	snm_sync #(.RESET_VAL(1'b1)) u_scl_sync (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.pin_in  (scl_i),
		.pin_sync(scl_s)
	);

	snm_sync #(.RESET_VAL(1'b1)) u_sda_sync (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.pin_in  (sda_i),
		.pin_sync(sda_s)
	);

	// Quarter-bit enable divider
	assign tick = (qcnt_reg == 16'h0000);
	always_comb begin
		qcnt_next = tick ? 16'(QTR_CYC - 1) : qcnt_reg - 16'h0001;
	end

	// Byte to shift out for each step of the transaction
	assign xmit = (seq_reg != snm_pkg::SQ_RDATA);
	always_comb begin
		unique case (seq_next)
			snm_pkg::SQ_DEVW:  load_byte = {DEV_TYPE, sel_reg, snm_pkg::RW_WRITE}; // [R7] [R8]
			snm_pkg::SQ_DEVR:  load_byte = {DEV_TYPE, sel_reg, snm_pkg::RW_READ};  // [R7] [R8]
			snm_pkg::SQ_AHI:   load_byte = {snm_pkg::HI_ADDR_PAD, addr_reg[12:8]}; // [R9]
			snm_pkg::SQ_ALO:   load_byte = addr_reg[7:0];                          // [R9]
			snm_pkg::SQ_WDATA: load_byte = wr_data;
			default:           load_byte = 8'h00;
		endcase
	end

	// Bus sequencer: four quarters per bit, all moves except leaving idle wait for the enable
	always_comb begin
		state_next    = state_reg;
		seq_next      = seq_reg;
		q_next        = q_reg;
		bit_next      = bit_reg;
		sh_next       = sh_reg;
		rem_next      = rem_reg;
		read_next     = read_reg;
		sel_next      = sel_reg;
		addr_next     = addr_reg;
		nak_next      = nak_reg;
		scl_oe_next   = scl_oe_reg;
		sda_oe_next   = sda_oe_reg;
		rd_data_next  = rd_data_reg;
		rd_valid_next = 1'b0;
		wr_take_next  = 1'b0;
		done_next     = 1'b0;
		nack_next     = nack_reg;
		hold          = 1'b0;
		load          = 1'b0;
		unique case (state_reg)
			snm_pkg::ST_IDLE: begin
				scl_oe_next = 1'b0;
				sda_oe_next = 1'b0;
				q_next      = snm_pkg::Q_DRIVE;
				// Every command opens with a start, also after a brown-out
				if (cmd_valid && ready_reg) begin // [R21]
					state_next = snm_pkg::ST_START;
					read_next  = cmd_read;
					sel_next   = cmd_sel;
					addr_next  = cmd_addr;
					rem_next   = cmd_len;
					nack_next  = 1'b0;
					seq_next   = (cmd_read && !cmd_set_addr) ? snm_pkg::SQ_DEVR : snm_pkg::SQ_DEVW;
				end
			end
			snm_pkg::ST_START: begin
				if (tick) begin
					unique case (q_reg)
						snm_pkg::Q_DRIVE: sda_oe_next = 1'b0;
						snm_pkg::Q_RISE:  scl_oe_next = 1'b0;
						snm_pkg::Q_HIGH: begin
							hold        = !scl_s;
							sda_oe_next = scl_s; // [R2]
						end
						snm_pkg::Q_FALL: begin
							scl_oe_next = 1'b1;
							state_next  = snm_pkg::ST_BITS;
							load        = 1'b1;
						end
					endcase
				end
			end
			snm_pkg::ST_BITS: begin
				if (tick) begin
					unique case (q_reg)
						// Data changes only while SCL is held low
						snm_pkg::Q_DRIVE: begin // [R3]
							if (bit_reg != snm_pkg::ACK_BIT) begin
								sda_oe_next = xmit && !sh_reg[7]; // [R13]
							end else begin
								// Released when listening; ack low only if more is wanted
								sda_oe_next = !xmit && (rem_reg != '0); // [R4] [R19]
							end
						end
						snm_pkg::Q_RISE: scl_oe_next = 1'b0;
						snm_pkg::Q_HIGH: begin
							hold = !scl_s;
							if (scl_s && !xmit && bit_reg != snm_pkg::ACK_BIT) begin
								sh_next = {sh_reg[6:0], sda_s};
							end
							if (scl_s && xmit && bit_reg == snm_pkg::ACK_BIT) begin
								nak_next = sda_s; // [R4]
							end
						end
						snm_pkg::Q_FALL: begin
							scl_oe_next = 1'b1;
							if (bit_reg != snm_pkg::ACK_BIT) begin
								bit_next = bit_reg + 4'h1;
								if (xmit) begin
									sh_next = {sh_reg[6:0], 1'b0};
								end else if (bit_reg == snm_pkg::LAST_BIT) begin
									rd_data_next  = sh_reg;
									rd_valid_next = 1'b1;
								end
							end else if (xmit && nak_reg) begin
								// Refused byte, e.g. write-protected: give up cleanly
								nack_next  = 1'b1;
								state_next = snm_pkg::ST_STOP;
							end else begin
								unique case (seq_reg)
									snm_pkg::SQ_DEVW: begin
										seq_next = snm_pkg::SQ_AHI;
										load     = 1'b1;
									end
									snm_pkg::SQ_AHI: begin
										seq_next = snm_pkg::SQ_ALO;
										load     = 1'b1;
									end
									snm_pkg::SQ_DEVR: begin
										seq_next = snm_pkg::SQ_RDATA;
										load     = 1'b1;
									end
									snm_pkg::SQ_ALO: begin
										if (read_reg) begin
											// Repeated start turns the write into a read
											seq_next   = snm_pkg::SQ_DEVR;
											state_next = snm_pkg::ST_START;
										end else begin
											// Stay in this ack slot until the first byte arrives
											seq_next = wr_valid ? snm_pkg::SQ_WDATA : seq_reg;
											hold     = !wr_valid;
											load     = wr_valid;
										end
									end
									snm_pkg::SQ_WDATA: begin
										if (rem_reg == '0) begin
											state_next = snm_pkg::ST_STOP;
										end else begin
											// SCL stays low until the user has a byte
											hold     = !wr_valid;
											load     = wr_valid;
											rem_next = wr_valid ? rem_reg - 1'b1 : rem_reg;
										end
									end
									snm_pkg::SQ_RDATA: begin
										if (rem_reg == '0) begin
											state_next = snm_pkg::ST_STOP; // [R19]
										end else begin
											rem_next = rem_reg - 1'b1;
											load     = 1'b1;
										end
									end
									default: state_next = snm_pkg::ST_STOP;
								endcase
							end
						end
					endcase
				end
			end
			snm_pkg::ST_STOP: begin
				// Reached only after an ack slot, so SDA is ours
				if (tick) begin // [R20]
					unique case (q_reg)
						snm_pkg::Q_DRIVE: sda_oe_next = 1'b1;
						snm_pkg::Q_RISE:  scl_oe_next = 1'b0;
						snm_pkg::Q_HIGH: begin
							hold        = !scl_s;
							sda_oe_next = !scl_s; // [R1]
						end
						snm_pkg::Q_FALL: begin
							state_next = snm_pkg::ST_IDLE;
							done_next  = 1'b1;
						end
					endcase
				end
			end
		endcase
		if (tick && state_reg != snm_pkg::ST_IDLE && !hold) begin
			q_next = q_reg + 2'h1;
		end
		if (load) begin
			sh_next      = load_byte;
			bit_next     = 4'h0;
			wr_take_next = (seq_next == snm_pkg::SQ_WDATA);
		end
	end

	// State registers
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_reg    <= snm_pkg::ST_IDLE;
			seq_reg      <= snm_pkg::SQ_DEVW;
			q_reg        <= 2'h0;
			bit_reg      <= 4'h0;
			sh_reg       <= 8'h00;
			rem_reg      <= '0;
			read_reg     <= 1'b0;
			sel_reg      <= 3'h0;
			addr_reg     <= '0;
			nak_reg      <= 1'b0;
			scl_oe_reg   <= 1'b0;
			sda_oe_reg   <= 1'b0;
			rd_data_reg  <= 8'h00;
			rd_valid_reg <= 1'b0;
			wr_take_reg  <= 1'b0;
			done_reg     <= 1'b0;
			nack_reg     <= 1'b0;
			ready_reg    <= 1'b0;
			wp_reg       <= 1'b0;
			qcnt_reg     <= 16'h0000;
		end else begin
			state_reg    <= state_next;
			seq_reg      <= seq_next;
			q_reg        <= q_next;
			bit_reg      <= bit_next;
			sh_reg       <= sh_next;
			rem_reg      <= rem_next;
			read_reg     <= read_next;
			sel_reg      <= sel_next;
			addr_reg     <= addr_next;
			nak_reg      <= nak_next;
			scl_oe_reg   <= scl_oe_next;
			sda_oe_reg   <= sda_oe_next;
			rd_data_reg  <= rd_data_next;
			rd_valid_reg <= rd_valid_next;
			wr_take_reg  <= wr_take_next;
			done_reg     <= done_next;
			nack_reg     <= nack_next;
			ready_reg    <= (state_next == snm_pkg::ST_IDLE);
			wp_reg       <= wp_req;
			qcnt_reg     <= qcnt_next;
		end
	end

	// Open-drain: the pad level is always low, oe decides
	assign scl_o     = 1'b0;
	assign sda_o     = 1'b0;
	assign scl_oe    = scl_oe_reg;
	assign sda_oe    = sda_oe_reg;
	assign cmd_ready = ready_reg;
	assign wr_take   = wr_take_reg;
	assign rd_data   = rd_data_reg;
	assign rd_valid  = rd_valid_reg;
	assign done      = done_reg;
	assign nack_err  = nack_reg;
	assign wp_o      = wp_reg;

	// Bus-level checks
	chk_stop_cond: assert property (@(posedge clk_sys) disable iff (!rstn) // [R1]
		(state_reg == snm_pkg::ST_STOP && q_reg == snm_pkg::Q_HIGH && tick && scl_s)
		|=> (!sda_oe_reg && !scl_oe_reg && $past(sda_oe_reg)))
		else $error("stop edge not made with SCL high");
	chk_start_cond: assert property (@(posedge clk_sys) disable iff (!rstn) // [R2]
		(state_reg == snm_pkg::ST_START && q_reg == snm_pkg::Q_HIGH && tick && scl_s)
		|=> (sda_oe_reg && !scl_oe_reg && !$past(sda_oe_reg)))
		else $error("start edge not made with SCL high");
	chk_sda_steady: assert property (@(posedge clk_sys) disable iff (!rstn) // [R3]
		(state_reg == snm_pkg::ST_BITS && !scl_oe_reg && $past(!scl_oe_reg)) |-> $stable(sda_oe_reg))
		else $error("SDA moved while SCL high");
	chk_ack_release: assert property (@(posedge clk_sys) disable iff (!rstn) // [R4]
		(state_reg == snm_pkg::ST_BITS && bit_reg == snm_pkg::ACK_BIT && xmit && !scl_oe_reg) |-> !sda_oe_reg)
		else $error("SDA not released in ack slot");
	chk_dir_bit: assert property (@(posedge clk_sys) disable iff (!rstn) // [R8]
		(state_reg == snm_pkg::ST_BITS && bit_reg == 4'h0 && q_reg == snm_pkg::Q_DRIVE
		&& (seq_reg == snm_pkg::SQ_DEVR || seq_reg == snm_pkg::SQ_DEVW))
		|-> (sh_reg[0] == (seq_reg == snm_pkg::SQ_DEVR) && sh_reg[7:4] == DEV_TYPE))
		else $error("slave address direction wrong");
	chk_addr_hi: assert property (@(posedge clk_sys) disable iff (!rstn) // [R9]
		(state_reg == snm_pkg::ST_BITS && bit_reg == 4'h0 && seq_reg == snm_pkg::SQ_AHI)
		|-> (sh_reg == {snm_pkg::HI_ADDR_PAD, addr_reg[12:8]}))
		else $error("high address byte wrong");
	chk_read_nack: assert property (@(posedge clk_sys) disable iff (!rstn) // [R19]
		(state_reg == snm_pkg::ST_BITS && bit_reg == snm_pkg::ACK_BIT && !xmit && rem_reg == '0
		&& q_reg == snm_pkg::Q_FALL && tick) |-> !sda_oe_reg ##1 state_reg == snm_pkg::ST_STOP)
		else $error("last read byte not ended by nack and stop");
	chk_stop_owned: assert property (@(posedge clk_sys) disable iff (!rstn) // [R20]
		$rose(state_reg == snm_pkg::ST_STOP) |-> ($past(bit_reg) == snm_pkg::ACK_BIT && scl_oe_reg))
		else $error("stop begun outside an ack slot");
	chk_start_first: assert property (@(posedge clk_sys) disable iff (!rstn) // [R21]
		$fell(state_reg == snm_pkg::ST_IDLE) |-> state_reg == snm_pkg::ST_START && !cmd_ready)
		else $error("transaction without start");
	chk_nack_abort: assert property (@(posedge clk_sys) disable iff (!rstn) // [R4]
		(state_reg == snm_pkg::ST_BITS && bit_reg == snm_pkg::ACK_BIT && xmit && nak_reg
		&& q_reg == snm_pkg::Q_FALL && tick) |=> (state_reg == snm_pkg::ST_STOP && nack_err))
		else $error("refused byte did not end transfer");
endmodule

// File: snm_mem_model.sv
/*
 * Behavioural model of the byte-wide two-wire memory device.
 * Assumes pulled-up scl and sda wires resolved in the bench; it pulls sda low through sda_pull.
 */
`timescale 1ns/100ps

module snm_mem_model #(
	parameter logic [3:0] DEV_TYPE = 4'h9 // Arbitrary value, matched in the bench
) (
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic [2:0] sel,
	input  wire logic       wp,
	output logic            sda_pull
);
	logic [7:0]  mem [0:8191];
	logic [12:0] addr_reg;   // Survives start and stop, like the real latch
	logic [4:0]  ahi;
	logic [7:0]  sh;
	logic [7:0]  rbyte;
	logic [3:0]  cnt;
	logic [2:0]  st;         // 0 idle, 1 slave addr, 2 high, 3 low, 4 write, 5 read
	logic        tx;
	logic        ack;

	// Known contents so reads of untouched bytes are predictable
	initial begin
		for (int i = 0; i < 8192; i++)
			mem[i] = i[7:0] ^ 8'h3C;
		addr_reg = '0;
		st = '0;
		cnt = '0;
		tx = 1'b0;
		ack = 1'b0;
		sda_pull = 1'b0;
	end

	// Decode of a byte the master has sent
	task automatic take_byte();
		ack = 1'b1;
		case (st)
		3'h1: begin
			ack = (sh[7:4] == DEV_TYPE) && (sh[3:1] == sel);
			st = sh[0] ? 3'h5 : 3'h2;
		end
		3'h2: begin
			ahi = sh[4:0];
			st = 3'h3;
		end
		3'h3: begin
			addr_reg = {ahi, sh};
			st = 3'h4;
		end
		default: begin
			ack = !wp;
			if (!wp) begin
				mem[addr_reg] = sh;
				addr_reg = addr_reg + 13'h0001;
			end
		end
		endcase
	endtask

	// Start rearms the decoder from any state
	always @(negedge sda) begin
		if (scl === 1'b1) begin
			st = 3'h1;
			cnt = '0;
			tx = 1'b0;
			sda_pull = 1'b0;
		end
	end

	// Stop aborts and releases
	always @(posedge sda) begin
		if (scl === 1'b1) begin
			st = '0;
			sda_pull = 1'b0;
		end
	end

	// Sampling on the rising edge
	always @(posedge scl) begin
		if (st != 0 && cnt < 8) begin
			if (!tx)
				sh = {sh[6:0], sda};
			cnt = cnt + 4'h1;
			if (cnt == 8 && tx)
				addr_reg = addr_reg + 13'h0001;
			if (cnt == 8 && !tx)
				take_byte();
		end else if (st != 0) begin
			cnt = '0;
			if ((tx && sda) || (!tx && !ack))
				st = '0;
			tx = (st == 3'h5);
		end
	end

	// Driving on the falling edge
	always @(negedge scl) begin
		if (st == 0)
			sda_pull = 1'b0;
		else if (cnt == 8)
			sda_pull = !tx && ack;
		else if (tx) begin
			if (cnt == 0)
				rbyte = mem[addr_reg];
			sda_pull = !rbyte[7 - cnt];
		end else
			sda_pull = 1'b0;
	end
endmodule

// File: snm_ctrl_tb.sv
/*
 * Self-checking bench for the two-wire memory controller against a device model.
 * Runs the bus at a 50-clock quarter bit, so one bit costs 200 system clocks.
 */
`timescale 1ns/100ps

module snm_ctrl_tb;
	localparam logic [3:0] DEV_T = 4'h9; // Arbitrary value
	localparam logic [2:0] SEL   = 3'h5;
	localparam int unsigned QTR  = 50;    // Faster than the default bus; keeps the run short
	localparam int CYC_MAX       = 80000;
	logic        clk_sys = 1'b0;
	logic        rstn    = 1'b0;
	logic        cmd_valid, cmd_read, cmd_set_addr, cmd_ready;
	logic [2:0]  cmd_sel;
	logic [12:0] cmd_addr;
	logic [7:0]  cmd_len, wr_data, rd_data;
	logic        wr_valid, wr_take, rd_valid, done, nack_err, wp_req, wp_o;
	logic        scl_oe, sda_oe, sda_pull;
	wire logic   scl;
	wire logic   sda;
	logic [7:0]  wq [$];
	logic [7:0]  rq [$];
	int          err_total  = 0;
	int          num_checks = 0;
	int          cyc        = 0;
	int          stall      = 0;

	// Pull-ups on both wires
	assign scl = !scl_oe;
	assign sda = !(sda_oe || sda_pull);
	always #5 clk_sys = ~clk_sys;

	snm_ctrl #(.DEV_TYPE(DEV_T), .QTR_CYC(QTR)) u_snm_ctrl (.clk_sys(clk_sys), .rstn(rstn), .cmd_valid(cmd_valid),
		.cmd_read(cmd_read), .cmd_set_addr(cmd_set_addr), .cmd_sel(cmd_sel), .cmd_addr(cmd_addr),
		.cmd_len(cmd_len), .cmd_ready(cmd_ready), .wr_data(wr_data), .wr_valid(wr_valid),
		.wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid), .done(done), .nack_err(nack_err),
		.wp_req(wp_req), .wp_o(wp_o), .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(),
		.sda_oe(sda_oe));

	snm_mem_model #(.DEV_TYPE(DEV_T)) u_snm_mem_model (.scl(scl), .sda(sda), .sel(SEL), .wp(wp_o),
		.sda_pull(sda_pull));

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Hang guard: 400 bits of 200 clocks, with margin
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == CYC_MAX) begin
			err_total++;
			summarize();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One command; write bytes come from wq, read bytes land in rq
	task automatic run(input logic rd, input logic sa, input logic [2:0] sl, input logic [12:0] a,
		input logic [7:0] len, input logic nk);
		int n;
		n = 0;
		rq = {};
		while (cmd_ready !== 1'b1) begin
			@(posedge clk_sys);
			#1;
		end
		{cmd_read, cmd_set_addr, cmd_sel, cmd_addr, cmd_len} = {rd, sa, sl, a, len};
		wr_valid = (wq.size() > 0) && (stall == 0);
		if (wq.size() > 0)
			wr_data = wq[0];
		cmd_valid = 1'b1;
		@(posedge clk_sys);
		#1;
		cmd_valid = 1'b0;
		while (done !== 1'b1 && n < 90000) begin
			@(posedge clk_sys);
			#1;
			n++;
			if (rd_valid === 1'b1)
				rq.push_back(rd_data);
			if (wr_take === 1'b1 && wq.size() > 0)
				void'(wq.pop_front());
			wr_valid = (wq.size() > 0) && (n >= stall);
			if (wq.size() > 0)
				wr_data = wq[0];
		end
		chk(done, 1'b1);
		chk({scl, sda}, 2'b11);
		chk(nack_err, nk);
		wq = {};
		wr_valid = 1'b0;
	endtask

	// Write across the top of memory; second byte wraps to zero
	task automatic t_wrap_write();
		wq = '{8'hC3, 8'h81};
		run(1'b0, 1'b1, SEL, 13'h1FFF, 8'h01, 1'b0);
		chk(u_snm_mem_model.mem[13'h1FFF], 8'hC3);
		chk(u_snm_mem_model.mem[0], 8'h81);
	endtask

	// Current-address read straight after a write, no polling
	task automatic t_cur_read();
		run(1'b1, 1'b0, SEL, 13'h0000, 8'h00, 1'b0);
		chk(16'(rq.size()), 16'h0001);
		chk(rq[0], 8'h01 ^ 8'h3C);
	endtask

	// Addressed two-byte read through the wrap point
	task automatic t_addr_read();
		run(1'b1, 1'b1, SEL, 13'h1FFF, 8'h01, 1'b0);
		chk(16'(rq.size()), 16'h0002);
		chk(rq[0], 8'hC3);
		chk(rq[1], 8'h81);
	endtask

	// Protected write is refused, memory untouched and latch left at the sent address
	task automatic t_protect();
		wp_req = 1'b1;
		wq = '{8'h77};
		run(1'b0, 1'b1, SEL, 13'h0100, 8'h00, 1'b1);
		chk(u_snm_mem_model.mem[13'h0100], 8'h3C);
		wp_req = 1'b0;
		run(1'b1, 1'b0, SEL, 13'h0000, 8'h00, 1'b0);
		chk(rq[0], 8'h3C);
	endtask

	// Wrong select bits: device stays silent
	task automatic t_bad_sel();
		wq = '{8'h55};
		run(1'b0, 1'b1, 3'h4, 13'h0002, 8'h00, 1'b1);
		chk(u_snm_mem_model.mem[2], 8'h3E);
	endtask

	// First write byte late: SCL waits low, the byte still lands once
	task automatic t_stall_write();
		stall = 8000;
		wq = '{8'hA5};
		run(1'b0, 1'b1, SEL, 13'h0010, 8'h00, 1'b0);
		stall = 0;
		chk(u_snm_mem_model.mem[13'h0010], 8'hA5);
		chk(u_snm_mem_model.addr_reg, 13'h0011);
	endtask

	// Reset, then the scenarios in order
	initial begin
		{cmd_valid, cmd_read, cmd_set_addr, cmd_sel, cmd_addr, cmd_len} = '0;
		{wr_data, wr_valid, wp_req} = '0;
		repeat (16) @(posedge clk_sys);
		#1;
		rstn = 1'b1;
		t_wrap_write();
		t_cur_read();
		t_addr_read();
		t_protect();
		t_bad_sel();
		t_stall_write();
		summarize();
	end
endmodule
